// ===== hw/empm_port_mux.sv
// top of the external memory port mux: registers, port selection and strobes
//
// What this block does
// - program source pin high fetches internal ROM; low fetches external memory.
// - low port select is config bit 3, high port select is bit 4.
// - low select clear gives general output; set gives address low byte.
// - high select clear gives general output; set gives address high byte.
// - registers need chip select bit, or in extended mode aux enabled and internal ROM.
// - config, low latch and high latch decode at 200h, 201h, 202h.
// - high select 0 drives latched value; 1 passes internal high address.
// - low select set latches low address byte on the address strobe.
// - internal ROM, low select 0 shows low latch, reset 00h, gated writes.
// - internal ROM, high select 0 shows high latch, reset 00h, gated writes.
// - external program memory: address on both ports, data port multiplexes low address and move data.
// - internal ROM: data port carries move data; ports follow own select.
// - strobes assert on every move, except below 200h with extended mode and aux off.
// - extended mode with aux off removes the three registers from the space.
// - data port holds no latch; data vanishes after the write cycle.
`timescale 1ns/1ps
module empm_port_mux (
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    input wire logic i_program_source_select,
    input wire logic i_chip_select_port_bit,
    input wire logic i_extended_access_mode,
    input wire logic i_aux_ram_disable,
    input wire empm_pkg::empm_move_t i_move,
    input wire empm_pkg::empm_cycle_t i_cycle,
    input wire logic [7:0] i_muxed_data_port,
    output logic [7:0] o_rdata,
    output logic o_rdata_valid,
    output logic [7:0] o_low_address_port,
    output logic [7:0] o_high_address_port,
    output logic [7:0] o_muxed_data_port,
    output logic o_muxed_data_port_oe_n,
    output logic o_rd_n,
    output logic o_wr_n,
    output logic o_internal_rom
);
    logic src_meta;
    logic src_sync;
    logic low_sel;
    logic high_sel;
    logic [7:0] low_latch;
    logic [7:0] high_latch;
    logic [7:0] addr_low_hold;
    logic access_ok;
    logic hit_cfg;
    logic hit_low;
    logic hit_high;
    logic strobe_en;
    logic [7:0] cfg_view;
    logic [7:0] next_low_port;
    logic [7:0] next_high_port;
    logic [7:0] next_data_port;
    logic next_data_oe_n;
    logic [7:0] next_rdata;

    // ------------------------------
    // program source pin synchroniser
    // ------------------------------
    always_ff @(posedge i_ref_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            src_meta <= 1'b1;
            src_sync <= 1'b1;
        end
        else
        begin
            src_meta <= i_program_source_select;
            src_sync <= src_meta;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_internal_rom <= 1'b1;
        end
        else
        begin
            o_internal_rom <= src_sync;
        end
    end

    // ------------------------------
    // access decode
    // ------------------------------
    empm_reg_access u_access (
        .i_ref_clk(i_ref_clk),
        .i_nrst(i_nrst),
        .i_chip_select_port_bit(i_chip_select_port_bit),
        .i_extended_access_mode(i_extended_access_mode),
        .i_aux_ram_disable(i_aux_ram_disable),
        .i_internal_rom(src_sync),
        .i_move(i_move),
        .o_access_ok(access_ok),
        .o_hit_cfg(hit_cfg),
        .o_hit_low(hit_low),
        .o_hit_high(hit_high),
        .o_strobe_en(strobe_en)
    );

    // ------------------------------
    // configuration register
    // ------------------------------
    always_ff @(posedge i_ref_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            low_sel <= empm_pkg::CFG_RESET[empm_pkg::LOW_SEL_BIT];
            high_sel <= empm_pkg::CFG_RESET[empm_pkg::HIGH_SEL_BIT];
        end
        else if (hit_cfg && i_move.write)
        begin
            low_sel <= i_move.wdata[empm_pkg::LOW_SEL_BIT];
            high_sel <= i_move.wdata[empm_pkg::HIGH_SEL_BIT];
        end
    end

    // ------------------------------
    // general purpose output latches
    // ------------------------------
    always_ff @(posedge i_ref_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            low_latch <= empm_pkg::LOW_LATCH_RESET;
        end
        else if (hit_low && i_move.write)
        begin
            low_latch <= i_move.wdata;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            high_latch <= empm_pkg::HIGH_LATCH_RESET;
        end
        else if (hit_high && i_move.write)
        begin
            high_latch <= i_move.wdata;
        end
    end

    // ------------------------------
    // low address hold on address strobe
    // ------------------------------
    always_ff @(posedge i_ref_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            addr_low_hold <= 8'h00;
        end
        else if (i_cycle.addr_strobe)
        begin
            addr_low_hold <= i_cycle.addr[7:0];
        end
    end

    // ------------------------------
    // port selection
    // ------------------------------
    always_comb
    begin
        cfg_view = 8'h00;
        cfg_view[empm_pkg::LOW_SEL_BIT] = low_sel;
        cfg_view[empm_pkg::HIGH_SEL_BIT] = high_sel;
        next_rdata = 8'h00;
        if (hit_cfg)
        begin
            next_rdata = cfg_view;
        end
        else if (hit_low)
        begin
            next_rdata = low_latch;
        end
        else if (hit_high)
        begin
            next_rdata = high_latch;
        end
        else if (i_move.valid)
        begin
            next_rdata = i_muxed_data_port;
        end
        if (!src_sync || low_sel)
        begin
            next_low_port = i_cycle.addr_strobe ? i_cycle.addr[7:0] : addr_low_hold;
        end
        else
        begin
            next_low_port = low_latch;
        end
        if (!src_sync || high_sel)
        begin
            next_high_port = i_cycle.addr[15:8];
        end
        else
        begin
            next_high_port = high_latch;
        end
        next_data_port = 8'h00;
        next_data_oe_n = 1'b1;
        if (i_move.valid && i_move.write)
        begin
            next_data_port = i_move.wdata;
            next_data_oe_n = 1'b0;
        end
        else if (!src_sync && i_cycle.addr_strobe)
        begin
            next_data_port = i_cycle.addr[7:0];
            next_data_oe_n = 1'b0;
        end
    end

    // ------------------------------
    // output registers
    // ------------------------------
    always_ff @(posedge i_ref_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_low_address_port <= empm_pkg::LOW_LATCH_RESET;
            o_high_address_port <= empm_pkg::HIGH_LATCH_RESET;
            o_muxed_data_port <= 8'h00;
            o_muxed_data_port_oe_n <= 1'b1;
        end
        else
        begin
            o_low_address_port <= next_low_port;
            o_high_address_port <= next_high_port;
            o_muxed_data_port <= next_data_port;
            o_muxed_data_port_oe_n <= next_data_oe_n;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_rd_n <= 1'b1;
            o_wr_n <= 1'b1;
            o_rdata <= 8'h00;
            o_rdata_valid <= 1'b0;
        end
        else
        begin
            o_rd_n <= !(i_move.valid && !i_move.write && strobe_en);
            o_wr_n <= !(i_move.valid && i_move.write && strobe_en);
            o_rdata <= next_rdata;
            o_rdata_valid <= i_move.valid && !i_move.write;
        end
    end

    // ------------------------------
    // checks
    // ------------------------------
    low_gp_view_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        (src_sync && !low_sel) |=> (o_low_address_port == $past(low_latch)))
        else $error("low port not showing its latch");
    high_gp_view_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        (src_sync && !high_sel) |=> (o_high_address_port == $past(high_latch)))
        else $error("high port not showing its latch");
    high_addr_pass_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        (!src_sync || high_sel) |=> (o_high_address_port == $past(i_cycle.addr[15:8])))
        else $error("high port not passing address");
    low_addr_hold_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        (low_sel && src_sync && i_cycle.addr_strobe) ##1 (low_sel && src_sync
        && !i_cycle.addr_strobe) |=> (o_low_address_port == $past(i_cycle.addr[7:0], 2)))
        else $error("low address not held after strobe");
    low_write_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        (hit_low && i_move.write) |=> (low_latch == $past(i_move.wdata)))
        else $error("low latch write lost");
    high_gate_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        (!i_chip_select_port_bit && !i_extended_access_mode) |=> $stable(high_latch))
        else $error("high latch written without access");
    strobe_move_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        (i_move.valid && i_move.write && !i_extended_access_mode) |=> !o_wr_n)
        else $error("write strobe missing");
    strobe_off_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        (i_move.valid && i_extended_access_mode && i_aux_ram_disable
        && i_move.addr < empm_pkg::AUX_SPACE_TOP) |=> (o_rd_n && o_wr_n))
        else $error("strobe active below map with aux off");
    data_release_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        (!i_move.valid && !(!src_sync && i_cycle.addr_strobe)) |=> o_muxed_data_port_oe_n)
        else $error("data port still driven after write");
    cfg_unused_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        hit_cfg |=> ((o_rdata & 8'he7) == 8'h00))
        else $error("unused config bits read nonzero");
endmodule : empm_port_mux

// ===== hw/empm_pkg.sv
// package: register map, field positions and carrier types of the external memory port mux
package empm_pkg;
    localparam logic [15:0] CFG_ADDR = 16'h0200;
    localparam logic [15:0] LOW_LATCH_ADDR = 16'h0201;
    localparam logic [15:0] HIGH_LATCH_ADDR = 16'h0202;
    localparam logic [15:0] AUX_SPACE_TOP = 16'h0200;
    localparam int LOW_SEL_BIT = 3;
    localparam int HIGH_SEL_BIT = 4;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [7:0] LOW_LATCH_RESET = 8'h00;
    localparam logic [7:0] HIGH_LATCH_RESET = 8'h00;

    // one external data move request from the core
    typedef struct packed {
        logic valid;
        logic write;
        logic [15:0] addr;
        logic [7:0] wdata;
    } empm_move_t;

    // core bus state for a code fetch or address phase
    typedef struct packed {
        logic fetch;
        logic [15:0] addr;
        logic addr_strobe;
    } empm_cycle_t;
endpackage : empm_pkg

// ===== hw/empm_reg_access.sv
// register access gate and decoder of the external memory port mux
`timescale 1ns/1ps
module empm_reg_access (
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    input wire logic i_chip_select_port_bit,
    input wire logic i_extended_access_mode,
    input wire logic i_aux_ram_disable,
    input wire logic i_internal_rom,
    input wire empm_pkg::empm_move_t i_move,
    output logic o_access_ok,
    output logic o_hit_cfg,
    output logic o_hit_low,
    output logic o_hit_high,
    output logic o_strobe_en
);
    logic in_map;
    // ------------------------------
    // access gate
    // ------------------------------
    always_comb
    begin
        if (!i_extended_access_mode)
        begin
            o_access_ok = i_chip_select_port_bit;
        end
        else
        begin
            o_access_ok = !i_aux_ram_disable && i_internal_rom;
        end
    end

    // ------------------------------
    // address decode
    // ------------------------------
    always_comb
    begin
        o_hit_cfg = 1'b0;
        o_hit_low = 1'b0;
        o_hit_high = 1'b0;
        if (i_move.addr == empm_pkg::CFG_ADDR)
        begin
            o_hit_cfg = i_move.valid && o_access_ok;
        end
        else if (i_move.addr == empm_pkg::LOW_LATCH_ADDR)
        begin
            o_hit_low = i_move.valid && o_access_ok;
        end
        else if (i_move.addr == empm_pkg::HIGH_LATCH_ADDR)
        begin
            o_hit_high = i_move.valid && o_access_ok;
        end
    end

    assign in_map = i_move.addr < empm_pkg::AUX_SPACE_TOP;
    // strobes suppressed below the map in extended mode when the aux space is disabled
    assign o_strobe_en = !(i_extended_access_mode && i_aux_ram_disable && in_map);

    gate_mode_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        (!i_extended_access_mode && !i_chip_select_port_bit) |-> !o_access_ok)
        else $error("register access open without chip select");
    gate_ard_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        (i_extended_access_mode && i_aux_ram_disable) |-> !(o_hit_cfg || o_hit_low || o_hit_high))
        else $error("register reached while aux space disabled");
endmodule : empm_reg_access

// ===== dv/empm_mem_model.sv
// partner model: external memory hanging on the multiplexed data port
`timescale 1ns/1ps
module empm_mem_model (
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    input wire logic i_wr_n,
    input wire logic i_bus_oe_n,
    input wire logic [7:0] i_bus,
    output logic [7:0] o_data
);
    // ----------------------------------------
    // storage, written on every low write strobe
    // ----------------------------------------
    logic [7:0] store;

    always_ff @(posedge i_ref_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            store <= 8'h00;
        else if (!i_wr_n)
            store <= i_bus;
    end

    // ----------------------------------------
    // output enable strapped active; inverse shown while the mux owns the bus
    // ----------------------------------------
    assign o_data = i_bus_oe_n ? store : ~store;
endmodule : empm_mem_model

// ===== dv/ext_memory_port_mux_tb.sv
// testbench of the external memory port mux
`timescale 1ns/1ps
module ext_memory_port_mux_tb;
    logic i_ref_clk, i_nrst, src, cs, extended_access_mode, aux_ram_disable, rvalid, oe_n, rd_n, wr_n, irom;
    empm_pkg::empm_move_t mv;
    empm_pkg::empm_cycle_t cyc;
    logic [7:0] rdata, lo, hi, dout, bus, mdat, ev;
    logic [7:0] exp_q[$];
    logic [15:0] lfsr;
    logic [15:0] a;
    int n_mismatch;
    int total_checks;

    empm_port_mux i_empm_port_mux (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst),
        .i_program_source_select(src), .i_chip_select_port_bit(cs),
        .i_extended_access_mode(extended_access_mode), .i_aux_ram_disable(aux_ram_disable), .i_move(mv),
        .i_cycle(cyc), .i_muxed_data_port(bus), .o_rdata(rdata), .o_rdata_valid(rvalid),
        .o_low_address_port(lo), .o_high_address_port(hi), .o_muxed_data_port(dout),
        .o_muxed_data_port_oe_n(oe_n), .o_rd_n(rd_n), .o_wr_n(wr_n), .o_internal_rom(irom));
    empm_mem_model i_empm_mem_model (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst),
        .i_wr_n(wr_n), .i_bus_oe_n(oe_n), .i_bus(bus), .o_data(mdat));
    assign bus = oe_n ? mdat : dout;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [15:0] nxt(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : nxt

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        total_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic mov(input logic w, input logic [15:0] ad, input logic [7:0] d,
        input logic s);
        if (!w)
            exp_q.push_back(d);
        mv = '{valid: 1'b1, write: w, addr: ad, wdata: d};
        @(posedge i_ref_clk);
        #5;
        mv.valid = 1'b0;
        chk({7'h0, w ? wr_n : rd_n}, {7'h0, !s}, "strobe");
        chk({7'h0, oe_n}, {7'h0, !w}, "drive enable");
        if (w)
            chk(dout, d, "drive data");
        @(posedge i_ref_clk);
        #5;
        chk({5'h0, oe_n, rd_n, wr_n}, 8'h07, "release");
    endtask : mov

    task automatic addr_phase(input logic [15:0] ad);
        cyc = '{fetch: 1'b0, addr: ad, addr_strobe: 1'b1};
        @(posedge i_ref_clk);
        #5;
        cyc.addr_strobe = 1'b0;
        chk(dout, src ? 8'h00 : ad[7:0], "address on data port");
        chk({7'h0, oe_n}, {7'h0, src}, "address drive");
        repeat (2) @(posedge i_ref_clk);
        #5;
    endtask : addr_phase

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : report_and_stop

    // ----------------------------------------
    // clock, result monitor, watchdog
    // ----------------------------------------
    initial
    begin
        i_ref_clk = 1'b0;
        forever #25 i_ref_clk = ~i_ref_clk;
    end

    always @(negedge i_ref_clk)
    begin
        if (rvalid === 1'b1)
        begin
            ev = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hxx;
            chk(rdata, ev, "read data");
        end
    end

    initial
    begin
        #(2000 * 50);
        n_mismatch++;
        report_and_stop();
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        n_mismatch = 0;
        total_checks = 0;
        lfsr = 16'hd199;
        i_nrst = 1'b0;
        {src, cs, extended_access_mode, aux_ram_disable} = 4'b1100;
        mv = '0;
        cyc = '0;
        repeat (3) @(posedge i_ref_clk);
        #5;
        i_nrst = 1'b1;
        repeat (3) @(posedge i_ref_clk);
        #5;
        mov(1'b0, 16'h0200, 8'h00, 1'b1);
        mov(1'b0, 16'h0201, 8'h00, 1'b1);
        mov(1'b0, 16'h0202, 8'h00, 1'b1);
        chk(lo, 8'h00, "low reset");
        chk(hi, 8'h00, "high reset");
        mov(1'b1, 16'h0201, 8'h5a, 1'b1);
        mov(1'b1, 16'h0202, 8'ha5, 1'b1);
        chk(lo, 8'h5a, "low latch");
        chk(hi, 8'ha5, "high latch");
        cs = 1'b0;
        mov(1'b1, 16'h0201, 8'h3c, 1'b1);
        mov(1'b0, 16'h0201, 8'h3c, 1'b1);
        chk(lo, 8'h5a, "refused write");
        cs = 1'b1;
        mov(1'b1, 16'h0200, 8'hff, 1'b1);
        mov(1'b0, 16'h0200, 8'h18, 1'b1);
        for (int k = 0; k < 4; k++)
        begin
            mov(1'b1, 16'h0200, {3'h0, k[1], k[0], 3'h0}, 1'b1);
            lfsr = nxt(lfsr);
            a = lfsr;
            addr_phase(a);
            chk(lo, k[0] ? a[7:0] : 8'h5a, "low select");
            chk(hi, k[1] ? a[15:8] : 8'ha5, "high select");
            cyc.addr = ~a;
            repeat (2) @(posedge i_ref_clk);
            #5;
            chk(lo, k[0] ? a[7:0] : 8'h5a, "low held");
            chk(hi, k[1] ? ~a[15:8] : 8'ha5, "high direct");
        end
        mov(1'b1, 16'h0200, 8'h00, 1'b1);
        src = 1'b0;
        lfsr = nxt(lfsr);
        a = lfsr;
        repeat (3) @(posedge i_ref_clk);
        #5;
        addr_phase(a);
        chk({7'h0, irom}, 8'h00, "external source");
        chk(lo, a[7:0], "external low");
        chk(hi, a[15:8], "external high");
        src = 1'b1;
        repeat (4) @(posedge i_ref_clk);
        #5;
        chk({7'h0, irom}, 8'h01, "internal source");
        {cs, extended_access_mode, aux_ram_disable} = 3'b010;
        mov(1'b1, 16'h0201, 8'hc3, 1'b1);
        mov(1'b0, 16'h0201, 8'hc3, 1'b1);
        aux_ram_disable = 1'b1;
        mov(1'b1, 16'h0201, 8'h96, 1'b1);
        mov(1'b0, 16'h0201, 8'h96, 1'b1);
        mov(1'b1, 16'h01ff, 8'h11, 1'b0);
        mov(1'b0, 16'h0150, 8'h96, 1'b0);
        aux_ram_disable = 1'b0;
        mov(1'b0, 16'h0201, 8'hc3, 1'b1);
        repeat (3) @(posedge i_ref_clk);
        chk(8'(exp_q.size()), 8'h00, "reads answered");
        report_and_stop();
    end
endmodule : ext_memory_port_mux_tb
